// >>> bench/exec_model.sv
/*
 Model of the execution unit's interrupt entry and segment call sequencer.
 Assumes requests come from the bench as one-cycle levels on mclk.
*/
`timescale 1ns/1ps
module exec_model (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       irqReq,
   input  wire logic       callReq,
   input  wire logic       segEn,
   input  wire logic [1:0] autoPushCount,
   output logic            irqEntry,
   output logic            segCall,
   output logic            segmentStackingEnable
);
   // ------------------------------------------------
   // Sequencer
   // ------------------------------------------------
   // Drops a request that comes while the push counter is nonzero; overlap is illegal
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irqEntry <= 1'h0;
         segCall  <= 1'h0;
      end else begin
         irqEntry <= irqReq && autoPushCount == 2'h0 && !irqEntry;
         segCall  <= callReq && autoPushCount == 2'h0 && !segCall;
      end
   end
   // Page pointer is never saved here; service code owns it
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) segmentStackingEnable <= 1'h0;
      else segmentStackingEnable <= segEn;
   end
endmodule

// >>> bench/tb_top.sv
/*
 Self-checking bench for the core system registers.
 Assumes the execution-unit model drives interrupt entry and segment calls.
*/
`timescale 1ns/1ps
module tb_top;
   typedef struct {int kind; logic [15:0] val;} note_t;
   localparam logic [7:0] A0 = core_sysreg_pkg::OFS_PTR_FIRST;
   localparam logic [7:0] A1 = core_sysreg_pkg::OFS_PTR_SECOND;
   localparam logic [7:0] AP = core_sysreg_pkg::OFS_PAGE_SEL;
   localparam logic [7:0] AM = core_sysreg_pkg::OFS_MODE_CTRL;
   logic                      mclk, rst_n, regWrEn, regHit, pageSetCmd, stkUser, stkWord;
   logic                      bus_request_pin, busRequest, stackInternal, oscillatorHalve;
   logic                      ctrlPinOe_n, irqEntry, segmentStackingEnable, segCall;
   logic                      irqReq, callReq, segEn, u, bp;
   logic [7:0]                regAddr, regWrData, regRdData, workRegAddr, splitPortIoMask;
   logic [7:0]                busPinOe_n, v, m;
   logic [4:0]                ptrSetBlock, b0, b1, b1r;
   logic [5:0]                pageSetNum, pagedGroupPage, p;
   logic [15:0]               stackAddr;
   logic [3:0]                workRegNum, r;
   logic [2:0]                coreClockDivider;
   logic [1:0]                autoPushCount;
   core_sysreg_pkg::ptr_set_t ptrSetCmd;
   core_sysreg_pkg::stk_op_t  stkOp;
   int                        errors, total_checks;
   note_t                     notes[$];
   note_t                     n;
   core_system_registers u_dut (.mclk(mclk), .rst_n(rst_n), .regWrEn(regWrEn),
      .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regHit(regHit),
      .ptrSetCmd(ptrSetCmd), .ptrSetBlock(ptrSetBlock), .pageSetCmd(pageSetCmd),
      .pageSetNum(pageSetNum), .stkOp(stkOp), .stkUser(stkUser), .stkWord(stkWord),
      .workRegNum(workRegNum), .workRegAddr(workRegAddr), .pagedGroupPage(pagedGroupPage),
      .stackAddr(stackAddr), .stackInternal(stackInternal), .oscillatorHalve(oscillatorHalve),
      .coreClockDivider(coreClockDivider), .bus_request_pin(bus_request_pin),
      .busRequest(busRequest), .splitPortIoMask(splitPortIoMask), .busPinOe_n(busPinOe_n),
      .ctrlPinOe_n(ctrlPinOe_n), .irqEntry(irqEntry),
      .segmentStackingEnable(segmentStackingEnable), .segCall(segCall),
      .autoPushCount(autoPushCount));
   exec_model u_exec (.mclk(mclk), .rst_n(rst_n), .irqReq(irqReq), .callReq(callReq),
      .segEn(segEn), .autoPushCount(autoPushCount), .irqEntry(irqEntry), .segCall(segCall),
      .segmentStackingEnable(segmentStackingEnable));
   // ------------------------------------------------
   // Clock, compare tasks and monitor
   // ------------------------------------------------
   initial begin
      mclk = 1'h0;
      forever #5 mclk = ~mclk;
   end
   task automatic note(input int k, input logic [15:0] e);
      notes.push_back('{k, e});
   endtask
   task automatic chk16(input string s, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      end
   endtask
   // Compared on the falling edge so combinational outputs have settled
   always @(negedge mclk) begin
      while (notes.size() > 0) begin
         n = notes.pop_front();
         case (n.kind)
            0: chk16("read data", n.val, {8'h00, regRdData});
            1: chk16("work addr", n.val, {8'h00, workRegAddr});
            2: chk16("stack addr", n.val, stackAddr);
            3: chk16("pins", n.val, {busPinOe_n, ctrlPinOe_n, busRequest, oscillatorHalve,
                                     coreClockDivider, stackInternal, 1'h0});
            4: chk16("page and push", n.val, {8'h00, pagedGroupPage, autoPushCount});
            default: chk16("hit", n.val, {15'h0000, regHit});
         endcase
      end
   end
   // ------------------------------------------------
   // Drivers
   // ------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      regWrEn <= 1'h1;
      regAddr <= a;
      regWrData <= d;
      @(posedge mclk);
      regWrEn <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      regAddr <= a;
      note(0, {8'h00, e});
   endtask
   task automatic ptr(input core_sysreg_pkg::ptr_set_t c, input logic [4:0] b);
      @(posedge mclk);
      ptrSetCmd <= c;
      ptrSetBlock <= b;
      @(posedge mclk);
      ptrSetCmd <= core_sysreg_pkg::PSET_NONE;
   endtask
   task automatic wreg(input logic [3:0] q, input logic [7:0] e);
      @(posedge mclk);
      workRegNum <= q;
      note(1, {8'h00, e});
   endtask
   // Word steps only move the pointer; no address note for those
   task automatic sop(input core_sysreg_pkg::stk_op_t o, input logic us, input logic w,
                      input logic [15:0] e);
      @(posedge mclk);
      stkOp <= o;
      stkUser <= us;
      stkWord <= w;
      if (!w) note(2, e);
      @(posedge mclk);
      stkOp <= core_sysreg_pkg::STK_NONE;
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #200000;
      errors++;
      stop_test();
   end
   // ------------------------------------------------
   // Tests
   // ------------------------------------------------
   initial begin
      {rst_n, regWrEn, regAddr, regWrData, ptrSetBlock, pageSetCmd, pageSetNum} = '0;
      {stkUser, stkWord, workRegNum, bus_request_pin, splitPortIoMask} = '0;
      {irqReq, callReq, segEn, b1r, errors, total_checks} = '0;
      ptrSetCmd = core_sysreg_pkg::PSET_NONE;
      stkOp = core_sysreg_pkg::STK_NONE;
      void'($urandom(18627));
      repeat (12) @(posedge mclk);
      rst_n <= 1'h1;
      rd(A0, 8'h00);
      rd(AP, 8'h00);
      rd(AM, 8'hE0);
      note(3, 16'h0022);
      @(posedge mclk);
      regAddr <= 8'h20;
      note(5, 16'h0000);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         b0 = (i == 0) ? 5'h03 : (i == 1) ? 5'h1F : 5'($urandom);
         b1 = 5'($urandom);
         r = 4'($urandom);
         ptr(core_sysreg_pkg::PSET_SINGLE, b0);
         rd(A0, {b0, 3'h0});
         rd(A1, {b1r, 3'h0});
         wreg(r, {b0[4:1], 4'h0} + {4'h0, r});
         ptr(core_sysreg_pkg::PSET_FIRST, b0);
         ptr(core_sysreg_pkg::PSET_SECOND, b1);
         b1r = b1;
         rd(A0, {b0, 3'h4});
         rd(A1, {b1, 3'h4});
         wreg(r, r[3] ? {b1, r[2:0]} : {b0, r[2:0]});
      end
      $display("test pointers done");
      wr(A0, 8'hFF);
      wr(A1, 8'hFF);
      wr(AP, 8'hFF);
      rd(A0, 8'hFC);
      rd(A1, 8'hFC);
      rd(AP, 8'hFC);
      wreg(4'h2, 8'hFA);
      note(4, 16'h00FC);
      for (int i = 0; i < 4; i++) begin
         p = 6'($urandom);
         @(posedge mclk);
         pageSetCmd <= 1'h1;
         pageSetNum <= p;
         @(posedge mclk);
         pageSetCmd <= 1'h0;
         rd(AP, {p, 2'h0});
         note(4, {8'h00, p, 2'h0});
      end
      $display("test page done");
      for (int i = 0; i < 8; i++) begin
         v = 8'($urandom);
         v[4:2] = 3'(i);
         m = 8'($urandom);
         u = 1'($urandom);
         bp = 1'($urandom);
         @(posedge mclk);
         splitPortIoMask <= m;
         stkUser <= u;
         bus_request_pin <= bp;
         wr(AM, v);
         rd(AM, v);
         note(3, {v[0] ? ~m : 8'h00, v[0], bp & v[1], v[5], v[4:2], u ? v[6] : v[7], 1'h0});
      end
      $display("test mode done");
      wr(8'hEE, 8'h01);
      wr(8'hEF, 8'h00);
      wr(8'hEC, 8'h00);
      wr(8'hED, 8'h40);
      sop(core_sysreg_pkg::STK_PUSH, 1'h0, 1'h0, 16'h00FF);
      rd(8'hEF, 8'hFF);
      sop(core_sysreg_pkg::STK_PUSH, 1'h1, 1'h1, 16'h0000);
      rd(8'hED, 8'h3E);
      sop(core_sysreg_pkg::STK_POP, 1'h0, 1'h0, 16'h00FF);
      rd(8'hEE, 8'h01);
      sop(core_sysreg_pkg::STK_POP, 1'h1, 1'h1, 16'h0000);
      rd(8'hED, 8'h40);
      $display("test stack done");
      for (int s = 0; s < 2; s++) begin
         wr(8'hEF, 8'h00);
         @(posedge mclk);
         segEn <= 1'(s);
         irqReq <= 1'h1;
         @(posedge mclk);
         irqReq <= 1'h0;
         repeat (6) @(posedge mclk);
         rd(8'hEF, s ? 8'hFD : 8'hFE);
         note(4, {8'h00, p, 2'h0});
      end
      wr(8'hEF, 8'h00);
      @(posedge mclk);
      callReq <= 1'h1;
      @(posedge mclk);
      callReq <= 1'h0;
      repeat (4) @(posedge mclk);
      rd(8'hEF, 8'hFF);
      $display("test entry done");
      repeat (2) @(posedge mclk);
      stop_test();
   end
endmodule

// >>> hw/core_system_registers.sv
/*
 System registers of the core: working-register pointers, page pointer,
 mode register, stack pointers and the automatic push sequence counter.
 Assumes the execution unit drives commands and register accesses
 synchronously to mclk; the external bus request pin is asynchronous.
*/
`timescale 1ns/1ps
module core_system_registers #(
   parameter int PAGES = 64
) (
   input  wire logic                        mclk,
   input  wire logic                        rst_n,
   input  wire logic                        regWrEn,
   input  wire logic [7:0]                  regAddr,
   input  wire logic [7:0]                  regWrData,
   output logic      [7:0]                  regRdData,
   output logic                             regHit,
   input  wire core_sysreg_pkg::ptr_set_t   ptrSetCmd,
   input  wire logic [4:0]                  ptrSetBlock,
   input  wire logic                        pageSetCmd,
   input  wire logic [5:0]                  pageSetNum,
   input  wire core_sysreg_pkg::stk_op_t    stkOp,
   input  wire logic                        stkUser,
   input  wire logic                        stkWord,
   input  wire logic [3:0]                  workRegNum,
   output logic      [7:0]                  workRegAddr,
   output logic      [5:0]                  pagedGroupPage,
   output logic      [15:0]                 stackAddr,
   output logic                             stackInternal,
   output logic                             oscillatorHalve,
   output logic      [2:0]                  coreClockDivider,
   input  wire logic                        bus_request_pin,
   output logic                             busRequest,
   input  wire logic [7:0]                  splitPortIoMask,
   output logic      [7:0]                  busPinOe_n,
   output logic                             ctrlPinOe_n,
   input  wire logic                        irqEntry,
   input  wire logic                        segmentStackingEnable,
   input  wire logic                        segCall,
   output logic      [1:0]                  autoPushCount
);
   if (PAGES < 1 || PAGES > 64) begin : g_pagesChk
      $error("PAGES out of range");
   end

   // -------------------------------------------------------------
   // Pointer registers
   // -------------------------------------------------------------
   logic [4:0] blockFirst_r;
   logic [4:0] blockSecond_r;
   logic       twin_r;
   logic [5:0] page_r;
   logic [7:0] mode_r;
   logic [15:0] ssp_r;
   logic [15:0] usp_r;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         blockFirst_r <= core_sysreg_pkg::PTR_RESET[7:3];
      end else if (ptrSetCmd == core_sysreg_pkg::PSET_SINGLE
                   || ptrSetCmd == core_sysreg_pkg::PSET_FIRST) begin
         blockFirst_r <= ptrSetBlock;
      end else if (regWrEn && regAddr == core_sysreg_pkg::OFS_PTR_FIRST) begin
         blockFirst_r <= regWrData[core_sysreg_pkg::BLOCK_MSB:core_sysreg_pkg::BLOCK_LSB];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         blockSecond_r <= core_sysreg_pkg::PTR_RESET[7:3];
      end else if (ptrSetCmd == core_sysreg_pkg::PSET_SECOND) begin
         blockSecond_r <= ptrSetBlock;
      end else if (regWrEn && regAddr == core_sysreg_pkg::OFS_PTR_SECOND) begin
         blockSecond_r <= regWrData[core_sysreg_pkg::BLOCK_MSB:core_sysreg_pkg::BLOCK_LSB];
      end
   end

   // One shared flag keeps both pointers reporting the same mode
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         twin_r <= core_sysreg_pkg::PTR_RESET[2];
      end else if (ptrSetCmd == core_sysreg_pkg::PSET_SINGLE) begin
         twin_r <= 1'b0;
      end else if (ptrSetCmd != core_sysreg_pkg::PSET_NONE) begin
         twin_r <= 1'b1;
      end else if (regWrEn && (regAddr == core_sysreg_pkg::OFS_PTR_FIRST
                               || regAddr == core_sysreg_pkg::OFS_PTR_SECOND)) begin
         twin_r <= regWrData[core_sysreg_pkg::TWIN_BIT];
      end
   end

   // -------------------------------------------------------------
   // Page pointer and mode register
   // -------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         page_r <= core_sysreg_pkg::PAGE_RESET[7:2];
      end else if (pageSetCmd) begin
         page_r <= pageSetNum;
      end else if (regWrEn && regAddr == core_sysreg_pkg::OFS_PAGE_SEL) begin
         page_r <= regWrData[core_sysreg_pkg::PAGE_MSB:core_sysreg_pkg::PAGE_LSB];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mode_r <= core_sysreg_pkg::MODE_RESET;
      end else if (regWrEn && regAddr == core_sysreg_pkg::OFS_MODE_CTRL) begin
         mode_r <= regWrData;
      end
   end

   // -------------------------------------------------------------
   // Stack pointers
   // -------------------------------------------------------------
   // Only the pointer moves; stack contents are never cleared by a pop
   logic [15:0] stkStep;
   logic [15:0] curSp;
   logic        useUser;
   logic        autoPush;
   assign stkStep  = stkWord ? 16'h0002 : 16'h0001;
   assign autoPush = autoPushCount != 2'd0;
   assign useUser  = stkUser && !autoPush;
   assign curSp    = useUser ? usp_r : ssp_r;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ssp_r <= core_sysreg_pkg::SP_RESET;
      end else if (autoPush) begin
         ssp_r <= ssp_r - 16'h0001;
      end else if (!stkUser && stkOp == core_sysreg_pkg::STK_PUSH) begin
         ssp_r <= ssp_r - stkStep;
      end else if (!stkUser && stkOp == core_sysreg_pkg::STK_POP) begin
         ssp_r <= ssp_r + stkStep;
      end else if (regWrEn && regAddr == core_sysreg_pkg::OFS_SSP_HI) begin
         ssp_r[15:8] <= regWrData;
      end else if (regWrEn && regAddr == core_sysreg_pkg::OFS_SSP_LO) begin
         ssp_r[7:0] <= regWrData;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         usp_r <= core_sysreg_pkg::SP_RESET;
      end else if (useUser && stkOp == core_sysreg_pkg::STK_PUSH) begin
         usp_r <= usp_r - stkStep;
      end else if (useUser && stkOp == core_sysreg_pkg::STK_POP) begin
         usp_r <= usp_r + stkStep;
      end else if (regWrEn && regAddr == core_sysreg_pkg::OFS_USP_HI) begin
         usp_r[15:8] <= regWrData;
      end else if (regWrEn && regAddr == core_sysreg_pkg::OFS_USP_LO) begin
         usp_r[7:0] <= regWrData;
      end
   end

   // Automatic push sequence: bytes still to push (pre-decrement each)
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         autoPushCount <= 2'd0;
      end else if (autoPush) begin
         autoPushCount <= autoPushCount - 2'd1;
      end else if (irqEntry) begin
         // PC word only; one more byte when segment stacking is enabled
         autoPushCount <= segmentStackingEnable ? 2'd3 : 2'd2;
      end else if (segCall) begin
         autoPushCount <= 2'd1;
      end
   end

   // Push address is the already decremented pointer
   always_comb begin
      if (autoPush) begin
         stackAddr = ssp_r - 16'h0001;
      end else if (stkOp == core_sysreg_pkg::STK_PUSH) begin
         stackAddr = curSp - stkStep;
      end else begin
         stackAddr = curSp;
      end
      stackInternal = useUser ? mode_r[core_sysreg_pkg::USR_STK_BIT]
                              : mode_r[core_sysreg_pkg::SYS_STK_BIT];
   end

   // -------------------------------------------------------------
   // Working-register address decode
   // -------------------------------------------------------------
   // Decode uses the registered pointers, so a write lands next instruction
   always_comb begin
      if (!twin_r) begin
         workRegAddr = {blockFirst_r[4:1], workRegNum};
      end else if (!workRegNum[3]) begin
         workRegAddr = {blockFirst_r, workRegNum[2:0]};
      end else begin
         workRegAddr = {blockSecond_r, workRegNum[2:0]};
      end
   end

   assign pagedGroupPage   = page_r;
   assign oscillatorHalve  = mode_r[core_sysreg_pkg::HALVE_BIT];
   assign coreClockDivider = mode_r[core_sysreg_pkg::DIV_MSB:core_sysreg_pkg::DIV_LSB];

   // -------------------------------------------------------------
   // Bus request and high impedance
   // -------------------------------------------------------------
   logic breqMeta_r;
   logic breqSync_r;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         breqMeta_r <= 1'b0;
         breqSync_r <= 1'b0;
      end else begin
         breqMeta_r <= bus_request_pin;
         breqSync_r <= breqMeta_r;
      end
   end
   assign busRequest = breqSync_r && mode_r[core_sysreg_pkg::BUS_REQUEST_PIN_BIT];

   // Low enable drives; I/O-configured split pins keep driving
   assign busPinOe_n  = {8{mode_r[core_sysreg_pkg::FLOAT_BIT]}} & ~splitPortIoMask;
   assign ctrlPinOe_n = mode_r[core_sysreg_pkg::FLOAT_BIT];

   // -------------------------------------------------------------
   // Read port
   // -------------------------------------------------------------
   always_comb begin
      regHit    = 1'b1;
      regRdData = 8'h00;
      if (regAddr == core_sysreg_pkg::OFS_PTR_FIRST) begin
         regRdData = {blockFirst_r, twin_r, 2'b00};
      end else if (regAddr == core_sysreg_pkg::OFS_PTR_SECOND) begin
         regRdData = {blockSecond_r, twin_r, 2'b00};
      end else if (regAddr == core_sysreg_pkg::OFS_PAGE_SEL) begin
         regRdData = {page_r, 2'b00};
      end else if (regAddr == core_sysreg_pkg::OFS_MODE_CTRL) begin
         regRdData = mode_r;
      end else if (regAddr == core_sysreg_pkg::OFS_USP_HI) begin
         regRdData = usp_r[15:8];
      end else if (regAddr == core_sysreg_pkg::OFS_USP_LO) begin
         regRdData = usp_r[7:0];
      end else if (regAddr == core_sysreg_pkg::OFS_SSP_HI) begin
         regRdData = ssp_r[15:8];
      end else if (regAddr == core_sysreg_pkg::OFS_SSP_LO) begin
         regRdData = ssp_r[7:0];
      end else begin
         regHit = 1'b0;
      end
   end

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   sequence s_singleSet;
      ptrSetCmd == core_sysreg_pkg::PSET_SINGLE;
   endsequence
   sequence s_twinSet;
      ptrSetCmd == core_sysreg_pkg::PSET_FIRST || ptrSetCmd == core_sysreg_pkg::PSET_SECOND;
   endsequence

   property p_firstBlock;
      @(posedge mclk) disable iff (!rst_n)
      (ptrSetCmd == core_sysreg_pkg::PSET_FIRST) |=> regAddr != core_sysreg_pkg::OFS_PTR_FIRST
         || regRdData[7:3] == $past(ptrSetBlock);
   endproperty
   a_firstBlock: assert property (p_firstBlock) else $error("first block not stored");

   property p_singleMode;
      @(posedge mclk) disable iff (!rst_n)
      s_singleSet ##1 (ptrSetCmd == core_sysreg_pkg::PSET_NONE)
         |-> workRegAddr[7:4] == $past(ptrSetBlock[4:1]);
   endproperty
   a_singleMode: assert property (p_singleMode) else $error("single group misplaced");

   property p_twinSet;
      @(posedge mclk) disable iff (!rst_n) s_twinSet |=> twin_r;
   endproperty
   a_twinSet: assert property (p_twinSet) else $error("twin flag not set");
   property p_singleClr;
      @(posedge mclk) disable iff (!rst_n) s_singleSet |=> !twin_r;
   endproperty
   a_singleClr: assert property (p_singleClr) else $error("twin flag not cleared");

   property p_lowZero;
      @(posedge mclk) disable iff (!rst_n)
      (regAddr == core_sysreg_pkg::OFS_PTR_SECOND || regAddr == core_sysreg_pkg::OFS_PAGE_SEL)
         |-> regRdData[1:0] == 2'b00;
   endproperty
   a_lowZero: assert property (p_lowZero) else $error("reserved bits not zero");

   property p_secondTwin;
      @(posedge mclk) disable iff (!rst_n)
      (twin_r && workRegNum[3]) |-> workRegAddr[7:3] == blockSecond_r;
   endproperty
   a_secondTwin: assert property (p_secondTwin) else $error("r8-r15 misplaced");
   property p_pageSet;
      @(posedge mclk) disable iff (!rst_n)
      pageSetCmd |=> pagedGroupPage == $past(pageSetNum);
   endproperty
   a_pageSet: assert property (p_pageSet) else $error("page not selected");

   property p_irqPush;
      @(posedge mclk) disable iff (!rst_n)
      (irqEntry && !autoPush && !segmentStackingEnable) |=> autoPush [*2] ##1 !autoPush;
   endproperty
   a_irqPush: assert property (p_irqPush) else $error("interrupt push length wrong");

   property p_pushDec;
      @(posedge mclk) disable iff (!rst_n)
      autoPush |=> ssp_r == $past(ssp_r) - 16'h0001;
   endproperty
   a_pushDec: assert property (p_pushDec) else $error("push did not predecrement");
   property p_float;
      @(posedge mclk) disable iff (!rst_n)
      !mode_r[core_sysreg_pkg::FLOAT_BIT] |-> busPinOe_n == 8'h00 && !ctrlPinOe_n;
   endproperty
   a_float: assert property (p_float) else $error("bus floated while clear");
endmodule

// >>> inc/core_sysreg_pkg.sv
/*
 Constants for the core system-register block: register offsets, field
 positions, reset values and stack-operation codes.
 Assumes a byte-wide register-file port inside the core.
*/
package core_sysreg_pkg;
   // -------------------------------------------------------------
   // Register offsets
   // -------------------------------------------------------------
   localparam logic [7:0] OFS_PTR_FIRST  = 8'h00_E8;
   localparam logic [7:0] OFS_PTR_SECOND = 8'h00_E9;
   localparam logic [7:0] OFS_PAGE_SEL   = 8'h00_EA;
   localparam logic [7:0] OFS_MODE_CTRL  = 8'h00_EB;
   localparam logic [7:0] OFS_USP_HI     = 8'h00_EC;
   localparam logic [7:0] OFS_USP_LO     = 8'h00_ED;
   localparam logic [7:0] OFS_SSP_HI     = 8'h00_EE;
   localparam logic [7:0] OFS_SSP_LO     = 8'h00_EF;
   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int BLOCK_MSB    = 7;
   localparam int BLOCK_LSB    = 3;
   localparam int TWIN_BIT     = 2;
   localparam int PAGE_MSB     = 7;
   localparam int PAGE_LSB     = 2;
   localparam int SYS_STK_BIT  = 7;
   localparam int USR_STK_BIT  = 6;
   localparam int HALVE_BIT    = 5;
   localparam int DIV_MSB      = 4;
   localparam int DIV_LSB      = 2;
   localparam int BUS_REQUEST_PIN_BIT     = 1;
   localparam int FLOAT_BIT    = 0;
   // -------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------
   localparam logic [7:0]  PTR_RESET  = 8'h00_00;
   localparam logic [7:0]  PAGE_RESET = 8'h00_00;
   localparam logic [7:0]  MODE_RESET = 8'h00_E0;
   localparam logic [15:0] SP_RESET   = 16'h0000;
   // -------------------------------------------------------------
   // Pointer-set commands and stack operations
   // -------------------------------------------------------------
   typedef enum logic [1:0] {PSET_NONE, PSET_SINGLE, PSET_FIRST, PSET_SECOND} ptr_set_t;
   typedef enum logic [1:0] {STK_NONE, STK_PUSH, STK_POP} stk_op_t;
   typedef enum logic [1:0] {ENTRY_IDLE, ENTRY_PC_LO, ENTRY_PC_HI, ENTRY_FLAGS} entry_t;
endpackage
